/* crs_pkg.sv */
package crs_pkg;
    // register indices of the plain register port
    localparam logic [3:0] REG_IN_FUNC   = 4'h0; // second input function select
    localparam logic [3:0] REG_IN_SIG    = 4'h1; // second input signal select
    localparam logic [3:0] REG_BIAS      = 4'h2; // bias, signed tenths of percent
    localparam logic [3:0] REG_GAIN      = 4'h3; // gain, tenths of percent
    localparam logic [3:0] REG_CARRIER   = 4'h4; // carrier frequency select code
    localparam logic [3:0] REG_METHOD    = 4'h5; // control method select
    localparam logic [3:0] REG_RATING    = 4'h6; // motor rating setting
    localparam logic [3:0] REG_POLES     = 4'h7; // motor pole count
    localparam logic [3:0] REG_MEASURE   = 4'h8; // motor constant measure select
    localparam logic [3:0] REG_MAXFREQ   = 4'h9; // max output frequency, 0.1 Hz
    localparam logic [3:0] REG_UPPER     = 4'ha; // upper limit, 0.1 Hz
    localparam logic [3:0] REG_LOWER     = 4'hb; // lower limit, 0.1 Hz
    localparam logic [3:0] REG_PRIMARY   = 4'hc; // primary bias gain select
    localparam logic [3:0] REG_STATUS    = 4'hd; // status, read only
    localparam logic [3:0] REG_FREF      = 4'he; // frequency reference, read only
    // limits in tenths of percent
    localparam logic signed [15:0] BIAS_MIN = -16'sd990;
    localparam logic signed [15:0] BIAS_MAX = 16'sd2500;
    localparam logic signed [15:0] GAIN_MAX = 16'sd5000;
    localparam logic signed [15:0] PCT_FULL = 16'sd1000;
    // carrier codes, 0..6 = 0.8 1.1 1.6 2.5 5.0 7.5 10.0 kHz
    localparam logic [2:0] CAR_0K8  = 3'h0;
    localparam logic [2:0] CAR_1K6  = 3'h2;
    localparam logic [2:0] CAR_2K5  = 3'h3;
    localparam logic [2:0] CAR_5K0  = 3'h4;
    localparam logic [2:0] CAR_7K5  = 3'h5;
    localparam logic [2:0] CAR_10K  = 3'h6;
    // frequency thresholds in 0.1 Hz
    localparam logic [15:0] F_1HZ   = 16'h000a;
    localparam logic [15:0] F_5HZ   = 16'h0032;
    localparam logic [15:0] F_10HZ  = 16'h0064;
    localparam logic [15:0] F_15HZ  = 16'h0096;
    localparam logic [15:0] F_120HZ = 16'h04b0;
    // reset values
    localparam logic [15:0] MAXF_RST   = 16'h0258;
    localparam logic [2:0]  SIG_RST    = 3'h4;
    localparam logic [2:0]  CAR_RST    = 3'h4;
    localparam logic [2:0]  POLES_RST  = 3'h4;
    localparam logic signed [15:0] GAIN_RST = 16'sd1000;
    // input signal ranges
    typedef enum logic [1:0] {crs_rng_5v, crs_rng_10v, crs_rng_4ma, crs_rng_0ma} crs_range_t;
    // measurement sequencer
    typedef enum logic [1:0] {crs_ms_idle, crs_ms_volt, crs_ms_slip} crs_meas_t;
endpackage

/* crs_carrier_ref.sv */
// Contract
// - signal select 3..6 picks input range
// - bias accepted only -99.0 to 250.0 percent
// - gain accepted only 0.0 to 500.0 percent
// - percentages scale the maximum output frequency
// - reference clamped to max, upper, lower limits
// - negative reference never reverses rotation
// - negative pid feedback becomes zero percent
// - primary bias gain select ignored here
// - volts-per-hertz offers seven carrier frequencies
// - vector mode offers four carrier frequencies
// - carrier group change only while stopped; a method write to vector still moves a low carrier to 2.5 kHz while running
// - single-phase carrier lowered below 5/10 Hz
// - three-phase carrier lowered below 10/15 Hz
// - method 0 volts-per-hertz, 1 vector
// - vector mode limits output to 1-120 Hz
// - vector with low carrier rewrites 2.5 kHz
// - poles default four, rating defaults own
// - measure 1 voltage, 2 slip compensation
// - function select routes second input
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module crs_carrier_ref
    import crs_pkg::*;
#(
    parameter int          ADC_W       = 10,   // normalized input width
    parameter bit          THREE_PHASE = 1'b0, // drive variant
    parameter logic [7:0]  OWN_RATING  = 8'h07 // own capacity code, arbitrary
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // run state and measured output frequency, 0.1 Hz
    input  wire logic              run_pin,
    input  wire logic [15:0]       out_freq,
    // normalized second input sample
    input  wire logic [ADC_W-1:0]  adc_sample,
    // results
    output logic      [15:0]       freq_ref,
    output logic      [15:0]       aux_ref,
    output logic      [15:0]       pid_measured_value,
    output logic      [15:0]       pid_bias,
    output logic      [2:0]        carrier_active,
    output logic                   vector_mode,
    output logic      [1:0]        input_range,
    output logic      [1:0]        measure_start
);
    initial begin
        if (ADC_W < 4 || ADC_W > 14) $error("crs_carrier_ref: ADC_W out of range");
    end

    // two-flop synchronisers for the pin-side inputs, plus a third stage for the words
    logic [1:0]       run_sync;
    logic [ADC_W-1:0] adc_s1, adc_s2, adc_s3;
    logic [15:0]      ofq_s1, ofq_s2, ofq_s3;
    logic [ADC_W-1:0] adc_q, next_adc_q;  // accepted input word
    logic [15:0]      ofq_q, next_ofq_q;  // accepted output frequency word
    // a word caught mid-change is not used: take it once two stages agree
    always_comb begin
        next_adc_q = adc_s2 == adc_s3 ? adc_s2 : adc_q;
        next_ofq_q = ofq_s2 == ofq_s3 ? ofq_s2 : ofq_q;
    end
    always_ff @(posedge sys_clk) begin
        run_sync <= {run_sync[0], run_pin};
        adc_s1   <= adc_sample;
        adc_s2   <= adc_s1;
        adc_s3   <= adc_s2;
        adc_q    <= next_adc_q;
        ofq_s1   <= out_freq;
        ofq_s2   <= ofq_s1;
        ofq_s3   <= ofq_s2;
        ofq_q    <= next_ofq_q;
    end
    wire logic running = run_sync[1];

    // carrier group: low group holds codes 0..2
    function automatic logic low_group(input logic [2:0] c);
        return c <= CAR_1K6;
    endfunction

    // parameter store
    logic [1:0]  second_input_function_select, next_func;
    logic [2:0]  second_input_signal_select, next_sig;
    logic signed [15:0] second_input_bias_percent, next_bias;
    logic signed [15:0] second_input_gain_percent, next_gain;
    logic [2:0]  carrier_frequency_select, next_car;
    logic        control_method_select, next_method;
    logic [7:0]  motor_rating_setting, next_rating;
    logic [2:0]  motor_pole_count, next_poles;
    logic [1:0]  motor_constant_measure_select, next_meas;
    logic [15:0] max_output_frequency, next_maxf;
    logic [15:0] upper_limit, next_upper;
    logic [15:0] lower_limit, next_lower;
    logic [1:0]  primary_bias_gain_select, next_prim;
    logic        reject_flag, next_reject;     // last write refused
    logic        measure_done, next_mdone;     // measurement launched

    // write decode with range checks
    always_comb begin
        next_func   = second_input_function_select;
        next_sig    = second_input_signal_select;
        next_bias   = second_input_bias_percent;
        next_gain   = second_input_gain_percent;
        next_car    = carrier_frequency_select;
        next_method = control_method_select;
        next_rating = motor_rating_setting;
        next_poles  = motor_pole_count;
        next_meas   = motor_constant_measure_select;
        next_maxf   = max_output_frequency;
        next_upper  = upper_limit;
        next_lower  = lower_limit;
        next_prim   = primary_bias_gain_select;
        next_reject = reject_flag;
        next_mdone  = 1'b0;
        // measurement request is a one-shot, cleared once launched
        if (motor_constant_measure_select != 2'h0 && !running) begin
            next_meas  = 2'h0;
            next_mdone = 1'b1;
        end
        if (reg_wr) begin
            next_reject = 1'b0;
            unique case (reg_addr)
                REG_IN_FUNC: next_func = reg_wdata[1:0];
                REG_IN_SIG: begin
                    // only codes 3..6 are legal
                    if (reg_wdata >= 16'h0003 && reg_wdata <= 16'h0006) next_sig = reg_wdata[2:0];
                    else next_reject = 1'b1;
                end
                REG_BIAS: begin
                    if ($signed(reg_wdata) >= BIAS_MIN && $signed(reg_wdata) <= BIAS_MAX)
                        next_bias = $signed(reg_wdata);
                    else next_reject = 1'b1;
                end
                REG_GAIN: begin
                    if ($signed(reg_wdata) >= 16'sd0 && $signed(reg_wdata) <= GAIN_MAX)
                        next_gain = $signed(reg_wdata);
                    else next_reject = 1'b1;
                end
                REG_CARRIER: begin
                    if (reg_wdata > 16'h0006) next_reject = 1'b1;
                    else if (control_method_select && low_group(reg_wdata[2:0])) next_reject = 1'b1;
                    else if (running && low_group(reg_wdata[2:0]) != low_group(carrier_frequency_select))
                        next_reject = 1'b1;
                    else next_car = reg_wdata[2:0];
                end
                REG_METHOD: begin
                    next_method = reg_wdata[0];
                    if (reg_wdata[0] && low_group(carrier_frequency_select)) next_car = CAR_2K5;
                end
                REG_RATING: next_rating = reg_wdata[7:0];
                REG_POLES: begin
                    if (reg_wdata == 16'h0002 || reg_wdata == 16'h0004 || reg_wdata == 16'h0006)
                        next_poles = reg_wdata[2:0];
                    else next_reject = 1'b1;
                end
                REG_MEASURE: next_meas = reg_wdata[1:0] == 2'h3 ? 2'h0 : reg_wdata[1:0];
                REG_MAXFREQ: next_maxf = reg_wdata;
                REG_UPPER: next_upper = reg_wdata;
                REG_LOWER: next_lower = reg_wdata;
                REG_PRIMARY: next_prim = reg_wdata[1:0];
                default: next_reject = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            second_input_function_select  <= 2'h0;
            second_input_signal_select    <= SIG_RST;
            second_input_bias_percent     <= 16'sd0;
            second_input_gain_percent     <= GAIN_RST;
            carrier_frequency_select      <= CAR_RST;
            control_method_select         <= 1'b0;
            motor_rating_setting          <= OWN_RATING;
            motor_pole_count              <= POLES_RST;
            motor_constant_measure_select <= 2'h0;
            max_output_frequency          <= MAXF_RST;
            upper_limit                   <= MAXF_RST;
            lower_limit                   <= 16'h0000;
            primary_bias_gain_select      <= 2'h0;
            reject_flag                   <= 1'b0;
            measure_done                  <= 1'b0;
        end else begin
            second_input_function_select  <= next_func;
            second_input_signal_select    <= next_sig;
            second_input_bias_percent     <= next_bias;
            second_input_gain_percent     <= next_gain;
            carrier_frequency_select      <= next_car;
            control_method_select         <= next_method;
            motor_rating_setting          <= next_rating;
            motor_pole_count              <= next_poles;
            motor_constant_measure_select <= next_meas;
            max_output_frequency          <= next_maxf;
            upper_limit                   <= next_upper;
            lower_limit                   <= next_lower;
            primary_bias_gain_select      <= next_prim;
            reject_flag                   <= next_reject;
            measure_done                  <= next_mdone;
        end
    end

    // scaling: pct = bias + (gain - bias) * x / full, tenths of percent
    logic signed [31:0] span, prod, pct;
    logic signed [31:0] hz_wide;
    logic [15:0]        hz, hi_lim, lo_lim, clamped;
    logic [15:0]        next_fref, next_aux, next_pv, next_pbias;
    always_comb begin
        span    = 32'(second_input_gain_percent) - 32'(second_input_bias_percent);
        prod    = span * $signed({1'b0, 31'(adc_q)});
        pct     = 32'(second_input_bias_percent) + (prod >>> ADC_W);
        // percent of maximum output frequency
        hz_wide = (pct * $signed({16'h0000, max_output_frequency})) / 32'sd1000;
        hz      = hz_wide < 0 ? 16'h0000 : (hz_wide > 32'sd65535 ? 16'hffff : hz_wide[15:0]);
        // limits; vector mode narrows them
        hi_lim  = upper_limit < max_output_frequency ? upper_limit : max_output_frequency;
        lo_lim  = lower_limit;
        if (control_method_select) begin
            if (hi_lim > F_120HZ) hi_lim = F_120HZ;
            if (lo_lim < F_1HZ) lo_lim = F_1HZ;
        end
        clamped = hz > hi_lim ? hi_lim : (hz < lo_lim ? lo_lim : hz);
        next_fref  = freq_ref;
        next_aux   = 16'h0000;
        next_pv    = 16'h0000;
        next_pbias = 16'h0000;
        unique case (second_input_function_select)
            2'h0: next_fref = clamped;
            2'h1: next_pv = pct < 0 ? 16'h0000 : (pct > 32'sd65535 ? 16'hffff : pct[15:0]);
            2'h2: next_pbias = pct[15:0];
            2'h3: next_aux = pct[15:0];
        endcase
    end

    // automatic carrier lowering at low output frequency
    logic [2:0]  next_carrier;
    logic [15:0] thr_a, thr_b;
    always_comb begin
        thr_a = THREE_PHASE ? F_10HZ : F_5HZ;
        thr_b = THREE_PHASE ? F_15HZ : F_10HZ;
        next_carrier = carrier_frequency_select;
        if (carrier_frequency_select == CAR_7K5 && ofq_q < thr_a) next_carrier = CAR_5K0;
        if (carrier_frequency_select == CAR_10K) begin
            if (ofq_q < thr_a) next_carrier = CAR_5K0;
            else if (ofq_q < thr_b) next_carrier = CAR_7K5;
        end
    end

    // read mux
    logic [15:0] next_rdata;
    always_comb begin
        unique case (reg_addr)
            REG_IN_FUNC: next_rdata = {14'h0000, second_input_function_select};
            REG_IN_SIG:  next_rdata = {13'h0000, second_input_signal_select};
            REG_BIAS:    next_rdata = second_input_bias_percent;
            REG_GAIN:    next_rdata = second_input_gain_percent;
            REG_CARRIER: next_rdata = {13'h0000, carrier_frequency_select};
            REG_METHOD:  next_rdata = {15'h0000, control_method_select};
            REG_RATING:  next_rdata = {8'h00, motor_rating_setting};
            REG_POLES:   next_rdata = {13'h0000, motor_pole_count};
            REG_MEASURE: next_rdata = {14'h0000, motor_constant_measure_select};
            REG_MAXFREQ: next_rdata = max_output_frequency;
            REG_UPPER:   next_rdata = upper_limit;
            REG_LOWER:   next_rdata = lower_limit;
            REG_PRIMARY: next_rdata = {14'h0000, primary_bias_gain_select};
            REG_STATUS:  next_rdata = {10'h000, carrier_active, running, measure_done, reject_flag};
            REG_FREF:    next_rdata = freq_ref;
            default:     next_rdata = 16'h0000;
        endcase
        if (!reg_rd) next_rdata = 16'h0000;
    end

    // output registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata          <= 16'h0000;
            freq_ref           <= 16'h0000;
            aux_ref            <= 16'h0000;
            pid_measured_value <= 16'h0000;
            pid_bias           <= 16'h0000;
            carrier_active     <= CAR_RST;
            vector_mode        <= 1'b0;
            input_range        <= 2'h1;
            measure_start      <= 2'h0;
        end else begin
            reg_rdata          <= next_rdata;
            freq_ref           <= next_fref;
            aux_ref            <= next_aux;
            pid_measured_value <= next_pv;
            pid_bias           <= next_pbias;
            carrier_active     <= next_carrier;
            vector_mode        <= control_method_select;
            input_range        <= 2'(second_input_signal_select - 3'h3);
            // pulse only on a real launch, even when software cancels the request in the launch cycle
            measure_start      <= next_mdone ? motor_constant_measure_select : 2'h0;
        end
    end

    // checks
    property p_carrier_vector;
        @(posedge sys_clk) disable iff (!rst_n) control_method_select |-> !low_group(carrier_frequency_select);
    endproperty
    a_carrier_vector: assert property (p_carrier_vector) else $error("low carrier in vector mode");
    property p_vec_rewrite;
        @(posedge sys_clk) disable iff (!rst_n)
            (reg_wr && reg_addr == REG_METHOD && reg_wdata[0] && low_group(carrier_frequency_select))
            |=> carrier_frequency_select == CAR_2K5;
    endproperty
    a_vec_rewrite: assert property (p_vec_rewrite) else $error("carrier not rewritten");
    property p_group_lock;
        @(posedge sys_clk) disable iff (!rst_n)
            running |=> low_group(carrier_frequency_select) == $past(low_group(carrier_frequency_select))
                        || $past(reg_wr && reg_addr == REG_METHOD);
    endproperty
    a_group_lock: assert property (p_group_lock) else $error("group changed while running");
    property p_bias_range;
        @(posedge sys_clk) disable iff (!rst_n) second_input_bias_percent >= BIAS_MIN && second_input_bias_percent <= BIAS_MAX;
    endproperty
    a_bias_range: assert property (p_bias_range) else $error("bias out of range");
    property p_gain_range;
        @(posedge sys_clk) disable iff (!rst_n) second_input_gain_percent >= 0 && second_input_gain_percent <= GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain out of range");
    property p_vec_hz;
        @(posedge sys_clk) disable iff (!rst_n)
            (control_method_select && second_input_function_select == 2'h0) [*2] |=> freq_ref <= F_120HZ;
    endproperty
    a_vec_hz: assert property (p_vec_hz) else $error("vector frequency above limit");
    property p_lower_10k;
        @(posedge sys_clk) disable iff (!rst_n)
            (carrier_frequency_select == CAR_10K && ofq_q < (THREE_PHASE ? F_10HZ : F_5HZ)) |=> carrier_active == CAR_5K0;
    endproperty
    a_lower_10k: assert property (p_lower_10k) else $error("carrier not lowered");
    property p_pv_pos;
        @(posedge sys_clk) disable iff (!rst_n) (second_input_function_select == 2'h1 && pct < 0) |=> pid_measured_value == 16'h0000;
    endproperty
    a_pv_pos: assert property (p_pv_pos) else $error("negative feedback passed");
    c_vec: cover property (@(posedge sys_clk) disable iff (!rst_n) control_method_select);
    c_lower: cover property (@(posedge sys_clk) disable iff (!rst_n) carrier_active != carrier_frequency_select);
    c_meas: cover property (@(posedge sys_clk) disable iff (!rst_n) measure_start != 2'h0);
endmodule
`default_nettype wire

/* crs_stage_model.sv */
`timescale 1ns/1ns
`default_nettype none
// power stage and motor: shaft speed follows the reference while running
module crs_stage_model (
    // clock
    input  wire logic        sys_clk,
    // run command from the bench and reference from the block
    input  wire logic        run_cmd,
    input  wire logic [15:0] freq_ref,
    // measured state back to the block
    output logic             run_pin,
    output logic      [15:0] out_freq
);
    // stopped motor reads zero speed, running motor tracks the reference
    always_ff @(posedge sys_clk) begin
        run_pin  <= run_cmd;
        out_freq <= run_cmd ? freq_ref : 16'h0000;
    end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import crs_pkg::*;
    logic        sys_clk = 1'b0;  // 25 MHz clock
    logic        rst_n = 1'b0;    // sync reset
    logic [3:0]  reg_addr = 4'h0; // register port
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        run_cmd = 1'b0;  // run request to the stage
    logic        run_pin;
    logic [15:0] out_freq;
    logic [9:0]  adc_sample = 10'h000;
    logic [15:0] freq_ref, aux_ref, pid_measured_value, pid_bias;
    logic [2:0]  carrier_active, carrier_tp; // single- and three-phase carriers
    logic        vector_mode;
    logic [1:0]  input_range, measure_start;
    int          error_cnt = 0;
    int          comparisons = 0;
    always #20 sys_clk = ~sys_clk;
    crs_carrier_ref dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_pin(run_pin), .out_freq(out_freq),
        .adc_sample(adc_sample), .freq_ref(freq_ref), .aux_ref(aux_ref), .pid_measured_value(pid_measured_value),
        .pid_bias(pid_bias), .carrier_active(carrier_active), .vector_mode(vector_mode),
        .input_range(input_range), .measure_start(measure_start));
    crs_stage_model stage (.sys_clk(sys_clk), .run_cmd(run_cmd), .freq_ref(freq_ref), .run_pin(run_pin),
        .out_freq(out_freq));
    // three-phase variant beside it, watched only for its carrier
    crs_carrier_ref #(.THREE_PHASE(1'b1)) dut_tp (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .run_pin(run_pin),
        .out_freq(out_freq), .adc_sample(adc_sample), .freq_ref(), .aux_ref(), .pid_measured_value(),
        .pid_bias(), .carrier_active(carrier_tp), .vector_mode(), .input_range(), .measure_start());
    // compare and count
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one-cycle write strobe
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task rchk(input string name, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(name, d, exp);
    endtask
    // let synchronisers and output registers settle
    task settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    // a write that must be refused raises the reject flag
    task rej(input string name, input logic [3:0] a, input logic [15:0] d);
        logic [15:0] s;
        wr(a, d);
        rd(REG_STATUS, s);
        chk(name, {15'h0000, s[0]}, 16'h0001);
    endtask
    task t_reset;
        rchk("poles", REG_POLES, 16'h0004);
        rchk("rating", REG_RATING, 16'h0007);
        rchk("gain", REG_GAIN, 16'h03e8);
        chk("carrier", {13'h0, carrier_active}, 16'h0004);
        chk("vector", {15'h0, vector_mode}, 16'h0000);
        $display("test reset done");
    endtask
    task t_signal;
        for (int i = 3; i <= 6; i++) begin
            wr(REG_IN_SIG, 16'(i));
            settle();
            chk("range", {14'h0, input_range}, 16'(i - 3));
        end
        rej("sig7", REG_IN_SIG, 16'h0007);
        chk("range kept", {14'h0, input_range}, 16'h0003);
        rej("unmapped", 4'hf, 16'h0001);
        $display("test signal done");
    endtask
    task t_limits;
        rej("bias low", REG_BIAS, 16'hfc21);
        wr(REG_BIAS, 16'hfc22);
        rchk("bias min", REG_BIAS, 16'hfc22);
        rej("bias high", REG_BIAS, 16'h09c5);
        rej("gain high", REG_GAIN, 16'h1389);
        wr(REG_GAIN, 16'h1388);
        rchk("gain max", REG_GAIN, 16'h1388);
        wr(REG_GAIN, 16'h03e8);
        $display("test limits done");
    endtask
    task t_scale;
        wr(REG_BIAS, 16'h012c);
        settle();
        chk("fref bias", freq_ref, 16'h00b4);
        @(posedge sys_clk);
        adc_sample <= 10'h200;
        settle();
        chk("fref mid", freq_ref, 16'h0186);
        wr(REG_PRIMARY, 16'h0001);
        settle();
        chk("fref primary", freq_ref, 16'h0186);
        wr(REG_BIAS, 16'h07d0);
        adc_sample <= 10'h000;
        settle();
        chk("fref max", freq_ref, 16'h0258);
        wr(REG_UPPER, 16'h01f4);
        settle();
        chk("fref upper", freq_ref, 16'h01f4);
        wr(REG_LOWER, 16'h0014);
        wr(REG_BIAS, 16'hfe0c);
        settle();
        chk("fref lower", freq_ref, 16'h0014);
        wr(REG_LOWER, 16'h0000);
        settle();
        chk("fref neg", freq_ref, 16'h0000);
        $display("test scale done");
    endtask
    task t_carrier;
        wr(REG_CARRIER, {13'h0, CAR_10K});
        wr(REG_BIAS, 16'h0032);
        run_cmd <= 1'b1;
        settle();
        chk("car 3hz", {13'h0, carrier_active}, {13'h0, CAR_5K0});
        chk("car3 3hz", {13'h0, carrier_tp}, {13'h0, CAR_5K0});
        wr(REG_BIAS, 16'h0078);
        settle();
        chk("car 7hz", {13'h0, carrier_active}, {13'h0, CAR_7K5});
        chk("car3 7hz", {13'h0, carrier_tp}, {13'h0, CAR_5K0});
        wr(REG_BIAS, 16'h00c8);
        settle();
        chk("car 12hz", {13'h0, carrier_active}, {13'h0, CAR_10K});
        chk("car3 12hz", {13'h0, carrier_tp}, {13'h0, CAR_7K5});
        wr(REG_BIAS, 16'h012c);
        settle();
        chk("car 18hz", {13'h0, carrier_active}, {13'h0, CAR_10K});
        chk("car3 18hz", {13'h0, carrier_tp}, {13'h0, CAR_10K});
        rej("group run", REG_CARRIER, {13'h0, CAR_0K8});
        chk("car kept", {13'h0, carrier_active}, {13'h0, CAR_10K});
        @(posedge sys_clk);
        run_cmd <= 1'b0;
        settle();
        $display("test carrier done");
    endtask
    task t_vector;
        wr(REG_CARRIER, {13'h0, CAR_0K8});
        settle();
        chk("car low", {13'h0, carrier_active}, {13'h0, CAR_0K8});
        wr(REG_METHOD, 16'h0001);
        wr(REG_BIAS, 16'h0000);
        settle();
        rchk("car rewrite", REG_CARRIER, {13'h0, CAR_2K5});
        chk("vector", {15'h0, vector_mode}, 16'h0001);
        chk("fref 1hz", freq_ref, F_1HZ);
        rej("car vec", REG_CARRIER, {13'h0, CAR_1K6});
        wr(REG_MAXFREQ, 16'h0fa0);
        wr(REG_UPPER, 16'h0fa0);
        wr(REG_BIAS, 16'h07d0);
        settle();
        chk("fref 120hz", freq_ref, F_120HZ);
        wr(REG_METHOD, 16'h0000);
        $display("test vector done");
    endtask
    task meas(input logic [15:0] v);
        logic hit;
        hit = 1'b0;
        wr(REG_MEASURE, v);
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk);
            #1;
            if (measure_start === v[1:0]) hit = 1'b1;
        end
        chk("measure", {15'h0, hit}, 16'h0001);
    endtask
    task t_func;
        meas(16'h0001);
        meas(16'h0002);
        wr(REG_BIAS, 16'hfe0c);
        wr(REG_IN_FUNC, 16'h0001);
        settle();
        chk("pv neg", pid_measured_value, 16'h0000);
        wr(REG_IN_FUNC, 16'h0002);
        settle();
        chk("pbias", pid_bias, 16'hfe0c);
        wr(REG_BIAS, 16'h012c);
        wr(REG_IN_FUNC, 16'h0003);
        settle();
        chk("aux", aux_ref, 16'h012c);
        $display("test function done");
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // cut a hang short well past the expected run length
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle();
        t_reset(); t_signal(); t_limits(); t_scale(); t_carrier(); t_vector(); t_func();
        close_out();
    end
endmodule
`default_nettype wire
